/* File: rtl/parallel_port_handshake.sv */
/*
 * Parallel handshake port: a data port and a control/status port on the
 * CPU I/O bus, eight output lines, eight input lines, four handshake
 * lines and three control lines toward up to four peripherals.
 * Assumes the CPU bus is synchronous to i_ref_clk and that all peer
 * lines are asynchronous to it.
 */
`timescale 1ns/100ps

// How it works
// - Port FD reads input byte, writes output byte.
// - Port FA is the control/status register.
// - Bit 2 reads 0 when peer accepts.
// - Bit 1 reads 0 when peer sends.
// - Bit 4 drives the unit-select output.
// - Eight out, eight in, four handshake, three control.
// - Control lines let four peers share connector.
// - Separate input and output enable lines driven.
module parallel_port_handshake
  import parallel_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input  wire logic          i_ref_clk,
  input  wire logic          i_nrst,
  // CPU I/O port side.
  input  wire io_req_t       i_io,
  output logic [7:0]         o_io_rdata,
  output logic               o_io_rvalid,
  output logic               o_wr_ready,
  // Peripheral connector side.
  output logic [7:0]         o_par_dout,
  input  wire logic [7:0]    i_par_din,
  output logic               o_out_strobe_n,
  output logic               o_in_ack_n,
  input  wire logic          i_peer_receive_ready_n,
  input  wire logic          i_peer_send_ready_n,
  output logic               o_unit_select,
  output logic               o_in_enable_n,
  output logic               o_out_enable_n
);

  localparam logic [TIMER_W-1:0] SETUP_LOAD  = TIMER_W'(SETUP_CYCLES);
  localparam logic [TIMER_W-1:0] STROBE_LOAD = TIMER_W'(STROBE_CYCLES);

  logic [7:0]         din_meta;
  logic [7:0]         din_sync;
  logic [1:0]         rx_ready_meta;
  logic               rx_ready_n_sync;
  logic               tx_ready_n_sync;
  logic               hit_data;
  logic               hit_ctrl;
  logic               unit_select;
  logic               in_enable;
  logic               out_enable;
  logic               overrun;
  logic               fifo_in_ready;
  logic [7:0]         fifo_out_data;
  logic               fifo_out_valid;
  logic               fifo_pop;
  logic [7:0]         out_byte;
  drain_state_t       drain_state;
  drain_state_t       next_drain_state;
  logic [TIMER_W-1:0] timer;
  logic               out_busy;
  logic [7:0]         status_byte;
  logic [TIMER_W-1:0] ack_timer;
  logic               ack_done;

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers. Every peer line passes two flip-flops before use; the
  // first stage feeds nothing but the second.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      din_meta        <= 8'h00;
      din_sync        <= 8'h00;
      rx_ready_meta   <= 2'b11;
      rx_ready_n_sync <= 1'b1;
      tx_ready_n_sync <= 1'b1;
    end else begin
      din_meta        <= i_par_din;
      din_sync        <= din_meta;
      rx_ready_meta   <= {i_peer_send_ready_n, i_peer_receive_ready_n};
      rx_ready_n_sync <= rx_ready_meta[0];
      tx_ready_n_sync <= rx_ready_meta[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Port decode for the two I/O addresses.
  assign hit_data = (i_io.addr == PARALLEL_DATA_ADDR);
  assign hit_ctrl = (i_io.addr == PARALLEL_CONTROL_STATUS_ADDR);

  // Control bits written by software through the control port.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      unit_select <= 1'b0;
      in_enable   <= 1'b0;
      out_enable  <= 1'b0;
    end else if (i_io.wr && hit_ctrl) begin
      unit_select <= i_io.wdata[UNIT_SELECT_BIT];
      in_enable   <= i_io.wdata[IN_ENABLE_BIT];
      out_enable  <= i_io.wdata[OUT_ENABLE_BIT];
    end
  end

  // Overrun is sticky: a write that finds the buffer full is dropped and
  // flagged. A read of the control port clears it, but a new overrun in
  // the same cycle wins so the event is never lost.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      overrun <= 1'b0;
    end else if (i_io.wr && hit_data && !fifo_in_ready) begin
      overrun <= 1'b1;
    end else if (i_io.rd && hit_ctrl) begin
      overrun <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status image. Bit 2 reads 0 only when a write will be kept and the
  // peer can take a byte, so polling software never loses data.
  assign out_busy = fifo_out_valid || (drain_state != DRAIN_IDLE);

  always_comb begin
    status_byte                   = 8'h00;
    status_byte[OUT_BUSY_BIT]     = out_busy;
    status_byte[SEND_READY_N_BIT] = tx_ready_n_sync;
    status_byte[RECV_READY_N_BIT] = rx_ready_n_sync
                                    || !fifo_in_ready;
    status_byte[UNIT_SELECT_BIT]  = unit_select;
    status_byte[IN_ENABLE_BIT]    = in_enable;
    status_byte[OUT_ENABLE_BIT]   = out_enable;
    status_byte[OVERRUN_BIT]      = overrun;
  end

  // Read data is registered: it answers one cycle after the read strobe
  // and holds until the next read. Unmapped ports read 8'h00.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_io_rdata  <= RDATA_RESET;
      o_io_rvalid <= 1'b0;
    end else begin
      o_io_rvalid <= i_io.rd;
      if (i_io.rd) begin
        if (hit_data) begin
          o_io_rdata <= din_sync;
        end else if (hit_ctrl) begin
          o_io_rdata <= status_byte;
        end else begin
          o_io_rdata <= 8'h00;
        end
      end
    end
  end

  // A read of the data port tells the peer its byte was taken with one
  // acknowledge pulse of the strobe width.
  assign ack_done = (ack_timer == TIMER_W'(1));

  // Acknowledge strobe timer; a read during a pulse restarts it.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ack_timer  <= '0;
      o_in_ack_n <= 1'b1;
    end else if (i_io.rd && hit_data) begin
      ack_timer  <= STROBE_LOAD;
      o_in_ack_n <= 1'b0;
    end else if (!o_in_ack_n) begin
      ack_timer  <= ack_timer - 1'b1;
      o_in_ack_n <= ack_done;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output buffer. The CPU may write a few bytes ahead of a slow peer;
  // o_wr_ready reports room so a writer can stall.
  byte_fifo #(
    .WIDTH (BYTE_W),
    .DEPTH (FIFO_WORDS)
  ) u_out_fifo (
    .i_ref_clk   (i_ref_clk),
    .i_nrst      (i_nrst),
    .i_in_data   (i_io.wdata),
    .i_in_valid  (i_io.wr && hit_data),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop)
  );

  assign o_wr_ready = fifo_in_ready;

  ////////////////////////////////////////////////////////////////////////
  // Drain sequencer. A byte leaves the buffer only when the peer shows
  // receive-ready; it is set up on the lines, strobed, and then one
  // release cycle passes before the next byte can go out.
  assign fifo_pop = (drain_state == DRAIN_IDLE) && fifo_out_valid
                    && !rx_ready_n_sync;

  always_comb begin
    next_drain_state = drain_state;
    unique case (drain_state)
      DRAIN_IDLE: begin
        if (fifo_pop) begin
          next_drain_state = DRAIN_SETUP;
        end
      end
      DRAIN_SETUP: begin
        if (timer == TIMER_W'(1)) begin
          next_drain_state = DRAIN_STROBE;
        end
      end
      DRAIN_STROBE: begin
        if (timer == TIMER_W'(1)) begin
          next_drain_state = DRAIN_RELEASE;
        end
      end
      DRAIN_RELEASE: begin
        next_drain_state = DRAIN_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      drain_state <= DRAIN_IDLE;
    end else begin
      drain_state <= next_drain_state;
    end
  end

  // Phase timer loads on entry to setup and to strobe, and counts down to zero.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      timer <= '0;
    end else if (fifo_pop) begin
      timer <= SETUP_LOAD;
    end else if (drain_state == DRAIN_SETUP && timer == TIMER_W'(1)) begin
      timer <= STROBE_LOAD;
    end else if (timer != '0) begin
      timer <= timer - 1'b1;
    end
  end

  // The output byte changes only when a new byte is taken from the
  // buffer, so the lines stay stable between writes.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      out_byte <= OUT_BYTE_RESET;
    end else if (fifo_pop) begin
      out_byte <= fifo_out_data;
    end
  end

  // Output strobe, low only in the strobe phase.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_out_strobe_n <= 1'b1;
    end else begin
      o_out_strobe_n <= (next_drain_state != DRAIN_STROBE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Connector outputs. Unit select and the two enables let several
  // peers share one bus; a lone peer may ignore all three.
  assign o_par_dout     = out_byte;
  assign o_unit_select  = unit_select;
  assign o_in_enable_n  = !in_enable;
  assign o_out_enable_n = !out_enable;

endmodule

/* File: common/parallel_port_pkg.sv */
/*
 * Shared constants and types for the parallel handshake port.
 * Assumes an 8-bit CPU I/O port bus and a 10 MHz system clock.
 */
package parallel_port_pkg;

  // I/O port addresses seen by the CPU.
  localparam logic [7:0] PARALLEL_CONTROL_STATUS_ADDR = 8'hfa;
  localparam logic [7:0] PARALLEL_DATA_ADDR           = 8'hfd;

  // Control and status field positions.
  localparam int OUT_BUSY_BIT       = 0;
  localparam int SEND_READY_N_BIT   = 1;
  localparam int RECV_READY_N_BIT   = 2;
  localparam int UNIT_SELECT_BIT    = 4;
  localparam int IN_ENABLE_BIT      = 5;
  localparam int OUT_ENABLE_BIT     = 6;
  localparam int OVERRUN_BIT        = 7;

  // Reset values.
  localparam logic [7:0] OUT_BYTE_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET    = 8'h00;

  // Timing: clock rate and handshake strobe timings in ns.
  localparam int CLK_PERIOD_NS   = 100;
  localparam int SETUP_TIME_NS   = 500;
  localparam int STROBE_TIME_NS  = 1000;
  localparam int SETUP_CYCLES    =
    (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYCLES   =
    (STROBE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W         = 4;

  // Output FIFO shape.
  localparam int FIFO_DEPTH = 4;
  localparam int BYTE_W     = 8;

  // One CPU I/O cycle: strobes are one-cycle pulses.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       rd;
    logic       wr;
  } io_req_t;

  // Output drain sequencer.
  typedef enum logic [1:0] {
    DRAIN_IDLE    = 2'b00,
    DRAIN_SETUP   = 2'b01,
    DRAIN_STROBE  = 2'b10,
    DRAIN_RELEASE = 2'b11
  } drain_state_t;

endpackage

/* File: rtl/byte_fifo.sv */
/*
 * Small flip-flop FIFO with valid/ready on both sides.
 * Assumes one clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_nrst,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic [WIDTH-1:0]      o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_idx;
  logic [AW-1:0]    rd_idx;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  ////////////////////////////////////////////////////////////////////////
  // Handshake terms; full and empty follow the true occupancy.
  assign o_in_ready  = (count != DEPTH_C);
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_idx];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  // Storage is written only, never reset, to keep it cheap.
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_idx] <= i_in_data;
    end
  end

  // Index and occupancy bookkeeping; indices wrap at DEPTH.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end

endmodule

/* File: bench/peer_model.sv */
/*
 * Behavioural peripheral on the parallel connector.
 * Assumes the bench steers hold, has and byte off the clock edge.
 */
`timescale 1ns/100ps
module peer_model #(
  parameter logic UNIT = 1'b1
) (
  input  wire logic       i_strobe_n,
  input  wire logic       i_sel,
  input  wire logic       i_hold,
  input  wire logic       i_has,
  input  wire logic [7:0] i_dout,
  input  wire logic [7:0] i_byte,
  output logic            o_rx_ready_n,
  output logic            o_tx_ready_n,
  output logic [7:0]      o_din
);
  logic [7:0] got [4];
  int         n_got = 0;
  logic       me;
  //////////////////////////////////////////////////////////////////////////
  // Only the selected unit answers; enables are ignored.
  assign me = (i_sel === UNIT);
  // Busy while stalled, and while a strobe is being taken.
  assign o_rx_ready_n = !me || i_hold || !i_strobe_n;
  assign o_tx_ready_n = !(me && i_has);
  // A released bus shows the inverse byte, so stale data cannot pass.
  assign o_din = (me && i_has) ? i_byte : ~i_byte;
  // Keep the first four bytes at their falling strobes, in arrival order; later strobes are only counted.
  always @(negedge i_strobe_n) begin
    if (n_got < 4) got[n_got] = i_dout;
    n_got++;
  end
endmodule

/* File: bench/parallel_port_handshake_asserts.sv */
/*
 * Timing checks on the ports of the parallel handshake port.
 * Assumes the bind below; sees only the top module's ports.
 */
`timescale 1ns/100ps
module parallel_port_handshake_asserts
  import parallel_port_pkg::*;
#(
  parameter int FIFO_WORDS = FIFO_DEPTH
) (
  input wire logic       i_ref_clk,
  input wire logic       i_nrst,
  input wire io_req_t    i_io,
  input wire logic [7:0] o_io_rdata,
  input wire logic       o_io_rvalid,
  input wire logic       o_wr_ready,
  input wire logic [7:0] o_par_dout,
  input wire logic [7:0] i_par_din,
  input wire logic       o_out_strobe_n,
  input wire logic       o_in_ack_n,
  input wire logic       i_peer_receive_ready_n,
  input wire logic       i_peer_send_ready_n,
  input wire logic       o_unit_select,
  input wire logic       o_in_enable_n,
  input wire logic       o_out_enable_n
);
  logic fa_wr;
  logic fa_rd;
  logic fd_rd;
  logic no_rd;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  //////////////////////////////////////////////////////////////////////////
  // Decoded CPU cycles.
  assign fa_wr = i_io.wr && i_io.addr == PARALLEL_CONTROL_STATUS_ADDR;
  assign fa_rd = i_io.rd && !i_io.wr &&
                 i_io.addr == PARALLEL_CONTROL_STATUS_ADDR;
  assign fd_rd = i_io.rd && i_io.addr == PARALLEL_DATA_ADDR;
  assign no_rd = i_io.rd && i_io.addr != PARALLEL_DATA_ADDR &&
                 i_io.addr != PARALLEL_CONTROL_STATUS_ADDR;
  //////////////////////////////////////////////////////////////////////////
  a_rd_answers: assert property (i_io.rd |=> o_io_rvalid)
    else $error("read not answered");
  a_no_stray_rvalid: assert property (!i_io.rd |=> !o_io_rvalid)
    else $error("read answer without read");
  a_strobe_ten_low: assert property ($fell(o_out_strobe_n) |=>
    !o_out_strobe_n [*8] ##1 !o_out_strobe_n ##1 o_out_strobe_n)
    else $error("strobe width wrong");
  a_dout_holds: assert property (!o_out_strobe_n |->
    $stable(o_par_dout)) else $error("byte moved under strobe");
  a_dout_setup: assert property ($changed(o_par_dout) |=>
    o_out_strobe_n [*4] ##1 !o_out_strobe_n)
    else $error("strobe setup wrong");
  a_unit_sel_wr: assert property (fa_wr |=>
    o_unit_select == $past(i_io.wdata[UNIT_SELECT_BIT]))
    else $error("unit select not written");
  a_enables_wr: assert property (fa_wr |=>
    o_in_enable_n == !$past(i_io.wdata[IN_ENABLE_BIT]) &&
    o_out_enable_n == !$past(i_io.wdata[OUT_ENABLE_BIT]))
    else $error("enable lines not written");
  a_status_sel: assert property (fa_rd |=>
    o_io_rdata[UNIT_SELECT_BIT] == o_unit_select && !o_io_rdata[3])
    else $error("status byte wrong");
  a_unmapped_zero: assert property (no_rd |=> o_io_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_ack_on_read: assert property (fd_rd |-> ##[1:2] !o_in_ack_n)
    else $error("no acknowledge after data read");
  c_strobe: cover property ($fell(o_out_strobe_n));
  c_full_wr: cover property (i_io.wr && !o_wr_ready);
  c_data_rd: cover property (fd_rd);
endmodule
bind parallel_port_handshake parallel_port_handshake_asserts #(
  .FIFO_WORDS(FIFO_WORDS)) i_parallel_port_handshake_asserts (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_io(i_io),
  .o_io_rdata(o_io_rdata), .o_io_rvalid(o_io_rvalid),
  .o_wr_ready(o_wr_ready), .o_par_dout(o_par_dout),
  .i_par_din(i_par_din), .o_out_strobe_n(o_out_strobe_n),
  .o_in_ack_n(o_in_ack_n),
  .i_peer_receive_ready_n(i_peer_receive_ready_n),
  .i_peer_send_ready_n(i_peer_send_ready_n),
  .o_unit_select(o_unit_select), .o_in_enable_n(o_in_enable_n),
  .o_out_enable_n(o_out_enable_n));

/* File: bench/tb.sv */
/*
 * Self-checking bench for the parallel handshake port.
 * Assumes the peer model and the bound checker beside it.
 */
`timescale 1ns/100ps
module tb;
  import parallel_port_pkg::*;
  typedef struct { logic [7:0] w; } row_t;
  logic i_ref_clk, i_nrst, rvalid, wr_ready, strobe_n, ack_n, sel;
  logic in_en_n, out_en_n, rx_n, tx_n, hold, has;
  logic [7:0] rdata, dout, din, pbyte, d;
  io_req_t io;
  int err_total = 0;
  int n_compared = 0;
  row_t rows [5] = '{'{8'h10}, '{8'h20}, '{8'h40}, '{8'h00}, '{8'h70}};
  //////////////////////////////////////////////////////////////////////////
  parallel_port_handshake i_parallel_port_handshake (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_io(io),
    .o_io_rdata(rdata), .o_io_rvalid(rvalid), .o_wr_ready(wr_ready),
    .o_par_dout(dout), .i_par_din(din), .o_out_strobe_n(strobe_n),
    .o_in_ack_n(ack_n), .i_peer_receive_ready_n(rx_n),
    .i_peer_send_ready_n(tx_n), .o_unit_select(sel),
    .o_in_enable_n(in_en_n), .o_out_enable_n(out_en_n));
  peer_model i_peer_model (
    .i_strobe_n(strobe_n), .i_sel(sel), .i_hold(hold), .i_has(has),
    .i_dout(dout), .i_byte(pbyte), .o_rx_ready_n(rx_n),
    .o_tx_ready_n(tx_n), .o_din(din));
  //////////////////////////////////////////////////////////////////////////
  // Clock at 10 MHz.
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  task automatic chk(input string n, input logic [7:0] s, e);
    n_compared++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // One-cycle strobes, launched on the falling edge.
  task automatic io_wr(input logic [7:0] a, w);
    @(negedge i_ref_clk) io = '{a, w, 1'b0, 1'b1};
    @(negedge i_ref_clk) io = '0;
  endtask
  task automatic io_rd(input logic [7:0] a, output logic [7:0] r);
    @(negedge i_ref_clk) io = '{a, 8'h00, 1'b1, 1'b0};
    @(negedge i_ref_clk) io = '0;
    chk("rvalid", {7'h00, rvalid}, 8'h01);
    r = rdata;
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // Watchdog: the whole run needs well under 2000 cycles.
  initial begin
    #(5000 * 100);
    err_total++;
    close_out();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    io = '0; hold = 1'b1; has = 1'b0; pbyte = 8'ha5; i_nrst = 1'b0;
    idle(8);
    i_nrst = 1'b1;
    chk("strobe", {7'h00, strobe_n}, 8'h01);
    chk("sel", {7'h00, sel}, 8'h00);
    chk("dout", dout, 8'h00);
    $display("test reset done");
    foreach (rows[k]) begin
      io_wr(8'hfa, rows[k].w);
      io_rd(8'hfa, d);
      chk("ctrl", d & 8'h78, rows[k].w & 8'h70);
      chk("sel", {7'h00, sel}, {7'h00, rows[k].w[4]});
      chk("ien", {7'h00, in_en_n}, {7'h00, !rows[k].w[5]});
      chk("oen", {7'h00, out_en_n}, {7'h00, !rows[k].w[6]});
    end
    io_rd(8'h80, d);
    chk("unmapped", d, 8'h00);
    $display("test registers done");
    io_wr(8'hfa, 8'h00);
    has = 1'b1;
    idle(4);
    io_rd(8'hfa, d);
    chk("unselected", d & 8'h02, 8'h02);
    io_wr(8'hfa, 8'h10);
    foreach (rows[k]) begin
      pbyte = 8'ha5 ^ rows[k].w;
      idle(4);
      io_rd(8'hfa, d);
      chk("send rdy", d & 8'h02, 8'h00);
      io_rd(8'hfd, d);
      chk("din", d, 8'ha5 ^ rows[k].w);
      chk("ack", {7'h00, ack_n}, 8'h00);
    end
    has = 1'b0;
    idle(4);
    io_rd(8'hfa, d);
    chk("send idle", d & 8'h02, 8'h02);
    // The acknowledge pulse of the last data read spans ten cycles.
    idle(3);
    chk("ack held", {7'h00, ack_n}, 8'h00);
    idle(1);
    chk("ack end", {7'h00, ack_n}, 8'h01);
    $display("test input done");
    for (int k = 1; k <= 5; k++) io_wr(8'hfd, 8'(k * 17));
    chk("full", {7'h00, wr_ready}, 8'h00);
    io_rd(8'hfa, d);
    chk("stat full", d & 8'h85, 8'h85);
    io_rd(8'hfa, d);
    chk("overrun clr", d & 8'h80, 8'h00);
    hold = 1'b0;
    for (int t = 0; t < 400 && i_peer_model.n_got < 4; t++) idle(1);
    chk("count", 8'(i_peer_model.n_got), 8'h04);
    for (int k = 0; k < 4; k++)
      chk("byte", i_peer_model.got[k], 8'((k + 1) * 17));
    idle(30);
    chk("dout hold", dout, 8'h44);
    io_rd(8'hfa, d);
    chk("stat idle", d & 8'h05, 8'h00);
    $display("test output done");
    // Mid-run reset: a stalled byte is dropped and the port comes back idle.
    hold = 1'b1;
    io_wr(8'hfd, 8'h3c);
    idle(2);
    io_rd(8'hfa, d);
    chk("pre rst busy", d & 8'h01, 8'h01);
    i_nrst = 1'b0;
    idle(2);
    chk("rst dout", dout, 8'h00);
    chk("rst sel", {7'h00, sel}, 8'h00);
    chk("rst strobe", {7'h00, strobe_n}, 8'h01);
    i_nrst = 1'b1;
    idle(2);
    io_rd(8'hfa, d);
    chk("rst stat", d & 8'hf1, 8'h00);
    chk("rst room", {7'h00, wr_ready}, 8'h01);
    $display("test mid reset done");
    close_out();
  end
endmodule
